// ### include/pms_cfg.svh
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// primary system control fields
`define PMS_PE_BIT 0
`define PMS_WP_BIT 16
`define PMS_PG_BIT 31

// extended system control fields
`define PMS_PSE_BIT 4
`define PMS_PAE_BIT 5
`define PMS_PGE_BIT 7
`define PMS_CONTEXT_ID_ENABLE_BIT 17
`define PMS_SUPERVISOR_EXEC_PREVENTION_BIT 20

// extended feature enable fields
`define PMS_LME_BIT 8
`define PMS_LMA_BIT 10
`define PMS_NXE_BIT 11

// reset values
`define PMS_PRIMARY_RST 32'h0000_0000
`define PMS_EXTENDED_RST 32'h0000_0000
`define PMS_FEATURE_RST 64'h0000_0000_0000_0000

// address widths and bit positions
`define PMS_LEGACY_WIDTH 32
`define PMS_LARGE_PAGE_WIDTH 40
`define PMS_PHYS_CEILING 52
`define PMS_WIDE_LIN_WIDTH 48
`define PMS_CANON_LSB 47
`define PMS_WIDE_USED_MSB 47

`endif

// ### include/pms_pkg.sv
package pms_pkg;

  typedef enum logic [1:0] {
    PMS_NONE,
    PMS_BITS32,
    PMS_EXTPHYS,
    PMS_WIDE
  } pms_mode_t;

  typedef enum logic [1:0] {
    PMS_SEL_PRIMARY,
    PMS_SEL_EXTENDED,
    PMS_SEL_FEATURE
  } pms_reg_sel_t;

  typedef struct packed {
    logic writeProtect;
    logic largePage;
    logic globalPage;
    logic contextId;
    logic execPrevention;
    logic noExecute;
  } pms_mods_t;

  typedef struct packed {
    logic [6:0] linWidth;
    logic [5:0] physWidthSmall;
    logic [5:0] physWidthLarge;
    logic page4k;
    logic page4m;
    logic page2m;
    logic page1g;
  } pms_geom_t;

  typedef struct packed {
    logic [31:0] primary;
    logic [31:0] extended;
    logic [63:0] feature;
    pms_mode_t mode;
    pms_mods_t mods;
    pms_geom_t geom;
    logic wrAck;
    logic fault;
    logic tlbFlush;
    logic [63:0] linOut;
    logic nonCanonical;
    logic passThrough;
  } pms_state_t;

endpackage

// ### verilog/pms_lin_shape.sv
`include "pms_cfg.svh"

module pms_lin_shape
  import pms_pkg::*;
(
  // selected mode
  input wire pms_mode_t mode,
  input wire logic is64,
  // address in and out
  input wire logic [63:0] linAddr,
  output logic [63:0] shaped,
  output logic nonCanonical
);

  always_comb
  begin
    // legacy modes and compatibility sub-mode see only the low half
    shaped = {32'h0000_0000, linAddr[31:0]}; // [R4] [R11] [R12]
    nonCanonical = 1'b0;
    if (mode == PMS_WIDE && is64)
    begin
      shaped = {16'h0000, linAddr[`PMS_WIDE_USED_MSB:0]}; // [R13]
      nonCanonical = !((&linAddr[63:`PMS_CANON_LSB]) ||
                       !(|linAddr[63:`PMS_CANON_LSB])); // [R13]
    end
  end

endmodule

// ### verilog/pms_paging_mode_select.sv
`include "pms_cfg.svh"

// Overview of operation
// R1: paging at bit 31, write-protect bit 16
// R2: extended control flags at bits 4,5,7,17,20
// R3: long-mode bit 8, no-execute bit 11
// R4: paging off passes addresses, ignores modifiers
// R5: paging needs protection enable set
// R6: paging without extension selects 32-bit mode
// R7: extension without long mode selects extended-physical
// R8: extension with long mode selects wide
// R9: long-mode-active equals paging AND long mode
// R10: writes never touch long-mode-active bit
// R11: legacy modes translate 32-bit linear addresses
// R12: compatibility sub-mode zeroes bits 47:32
// R13: 64-bit sub-mode canonical, ignores bits 63:48
// R14: over 32 physical bits only large pages
// R15: 4 MB pages only with large-page enable
// R16: 2 MB in both extended modes, 1 GB in wide if supported
// R17: execute-disable only extended modes with no-execute
// R18: context identifiers only in wide mode
// R19: long mode never seen in 32-bit mode
// R20: physical width capped by implementation maximum
// R21: software loads table base before paging
// R22: address-space switches need no flush
// R23: long-mode change while paging is refused
// R24: paging with long mode, no extension refused
// R25: clearing extension in wide mode refused
// R26: clearing paging with context ids refused
// R27: encoded mode plus pre-masked modifiers output
// R28: flags registered, update on retiring write
module pms_paging_mode_select
  import pms_pkg::*;
#(
  parameter int MAX_PHYS_WIDTH = `PMS_PHYS_CEILING,
  parameter int LIN_WIDTH = `PMS_WIDE_LIN_WIDTH,
  parameter bit HAS_WIDE_LARGE_PAGE = 1'b1,
  parameter bit HAS_GIGA_PAGE = 1'b1
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register write from instruction execution
  input wire logic wrEn,
  input wire pms_reg_sel_t wrSel,
  input wire logic [63:0] wrData,
  output logic wrAck,
  output logic fault,
  // register contents
  output logic [31:0] primarySystemControl,
  output logic [31:0] extendedSystemControl,
  output logic [63:0] extendedFeatureEnable,
  // mode to the translation unit
  output pms_mode_t mode,
  output pms_mods_t mods,
  output pms_geom_t geom,
  output logic tlbFlush,
  // linear address shaping
  input wire logic [63:0] linAddr,
  input wire logic linIs64,
  output logic [63:0] linOut,
  output logic nonCanonical,
  output logic passThrough
);

  // implementation maximum never exceeds the architectural ceiling
  localparam int PHYS_MAX = (MAX_PHYS_WIDTH > `PMS_PHYS_CEILING) ?
                            `PMS_PHYS_CEILING : MAX_PHYS_WIDTH;
  localparam int LARGE_MAX = (PHYS_MAX > `PMS_LARGE_PAGE_WIDTH) ?
                             `PMS_LARGE_PAGE_WIDTH : PHYS_MAX;
  localparam int LEGACY_MAX = (PHYS_MAX > `PMS_LEGACY_WIDTH) ?
                              `PMS_LEGACY_WIDTH : PHYS_MAX;
  localparam logic [5:0] PHYS_W = 6'(PHYS_MAX);
  localparam logic [5:0] LARGE_W = 6'(LARGE_MAX);
  localparam logic [5:0] LEGACY_W = 6'(LEGACY_MAX);
  localparam logic [6:0] WIDE_LIN_W = 7'(LIN_WIDTH);
  localparam logic [6:0] LEGACY_LIN_W = 7'(`PMS_LEGACY_WIDTH);

  pms_state_t s;
  pms_state_t next_s;

  logic [63:0] shapedAddr;
  logic shapedNonCanon;

  logic curPg;
  logic curPae;
  logic curLme;
  logic curPcide;
  logic newPg;
  logic newPe;
  logic refuse;
  logic nPg;
  logic nPae;
  logic nLme;
  logic nPse;
  logic nNxe;
  pms_mode_t nMode;

  pms_lin_shape u_shape (
    .mode(s.mode),
    .is64(linIs64),
    .linAddr(linAddr),
    .shaped(shapedAddr),
    .nonCanonical(shapedNonCanon)
  );

  always_comb
  begin
    next_s = s;
    next_s.wrAck = 1'b0;
    next_s.fault = 1'b0;
    curPg = s.primary[`PMS_PG_BIT];
    curPae = s.extended[`PMS_PAE_BIT];
    curLme = s.feature[`PMS_LME_BIT];
    curPcide = s.extended[`PMS_CONTEXT_ID_ENABLE_BIT];
    newPg = wrData[`PMS_PG_BIT];
    newPe = wrData[`PMS_PE_BIT];
    refuse = 1'b0;

    // write checks against the state before the write
    if (wrEn)
    begin
      next_s.wrAck = 1'b1;
      unique case (wrSel)
        PMS_SEL_PRIMARY:
        begin
          if (newPg && !newPe)
          begin
            refuse = 1'b1; // [R5]
          end
          if (newPg && !curPg && !curPae && curLme)
          begin
            refuse = 1'b1; // [R24] [R19]
          end
          if (!newPg && curPg && curPcide)
          begin
            refuse = 1'b1; // [R26]
          end
          if (!refuse)
          begin
            next_s.primary = wrData[31:0]; // [R1] [R28]
          end
        end
        PMS_SEL_EXTENDED:
        begin
          if (!wrData[`PMS_PAE_BIT] && curPae && curPg && curLme)
          begin
            refuse = 1'b1; // [R25] [R19]
          end
          if (!refuse)
          begin
            next_s.extended = wrData[31:0]; // [R2] [R28]
          end
        end
        PMS_SEL_FEATURE:
        begin
          if (curPg && (wrData[`PMS_LME_BIT] != curLme))
          begin
            refuse = 1'b1; // [R23] [R19]
          end
          if (!refuse)
          begin
            next_s.feature = wrData; // [R3] [R28]
            // written status bit is dropped, recomputed below
            next_s.feature[`PMS_LMA_BIT] = 1'b0; // [R10]
          end
        end
        default:
        begin
          refuse = 1'b0;
        end
      endcase
      next_s.fault = refuse;
    end

    nPg = next_s.primary[`PMS_PG_BIT];
    nPae = next_s.extended[`PMS_PAE_BIT];
    nLme = next_s.feature[`PMS_LME_BIT];
    nPse = next_s.extended[`PMS_PSE_BIT];
    nNxe = next_s.feature[`PMS_NXE_BIT];

    // status tracks the registered control bits every cycle
    next_s.feature[`PMS_LMA_BIT] = nPg & nLme; // [R9]

    // mode decode from the values being registered
    if (!nPg)
    begin
      nMode = PMS_NONE; // [R4]
    end
    else if (!nPae)
    begin
      nMode = PMS_BITS32; // [R6] [R19]
    end
    else if (!nLme)
    begin
      nMode = PMS_EXTPHYS; // [R7]
    end
    else
    begin
      nMode = PMS_WIDE; // [R8]
    end
    next_s.mode = nMode; // [R27]

    // modifiers cleared wherever the mode does not use them
    next_s.mods = '0;
    next_s.geom = '0;
    next_s.geom.linWidth = LEGACY_LIN_W; // [R11]
    next_s.geom.physWidthSmall = LEGACY_W;
    next_s.geom.physWidthLarge = LEGACY_W;
    unique case (nMode)
      PMS_NONE:
      begin
        next_s.mods = '0; // [R4] [R27]
      end
      PMS_BITS32:
      begin
        next_s.mods.writeProtect = next_s.primary[`PMS_WP_BIT]; // [R6]
        next_s.mods.largePage = nPse; // [R6]
        next_s.mods.globalPage = next_s.extended[`PMS_PGE_BIT]; // [R6]
        next_s.mods.execPrevention = next_s.extended[`PMS_SUPERVISOR_EXEC_PREVENTION_BIT]; // [R6]
        next_s.mods.noExecute = 1'b0; // [R17]
        next_s.geom.page4k = 1'b1; // [R15]
        next_s.geom.page4m = nPse; // [R15]
        if (HAS_WIDE_LARGE_PAGE && nPse)
        begin
          next_s.geom.physWidthLarge = LARGE_W; // [R14] [R20]
        end
      end
      PMS_EXTPHYS:
      begin
        next_s.mods.writeProtect = next_s.primary[`PMS_WP_BIT]; // [R7]
        next_s.mods.globalPage = next_s.extended[`PMS_PGE_BIT]; // [R7]
        next_s.mods.execPrevention = next_s.extended[`PMS_SUPERVISOR_EXEC_PREVENTION_BIT]; // [R7]
        next_s.mods.noExecute = nNxe; // [R7] [R17]
        next_s.geom.page4k = 1'b1; // [R16]
        next_s.geom.page2m = 1'b1; // [R16]
        next_s.geom.physWidthSmall = PHYS_W; // [R20]
        next_s.geom.physWidthLarge = PHYS_W; // [R20]
      end
      PMS_WIDE:
      begin
        next_s.mods.writeProtect = next_s.primary[`PMS_WP_BIT]; // [R8]
        next_s.mods.globalPage = next_s.extended[`PMS_PGE_BIT]; // [R8]
        next_s.mods.contextId = next_s.extended[`PMS_CONTEXT_ID_ENABLE_BIT]; // [R8] [R18]
        next_s.mods.execPrevention = next_s.extended[`PMS_SUPERVISOR_EXEC_PREVENTION_BIT]; // [R8]
        next_s.mods.noExecute = nNxe; // [R8] [R17]
        next_s.geom.linWidth = WIDE_LIN_W; // [R13]
        next_s.geom.page4k = 1'b1; // [R16]
        next_s.geom.page2m = 1'b1; // [R16]
        next_s.geom.page1g = HAS_GIGA_PAGE; // [R16]
        next_s.geom.physWidthSmall = PHYS_W; // [R20]
        next_s.geom.physWidthLarge = PHYS_W; // [R20]
      end
    endcase

    // flush only on a mode change; table-base switches keep cached entries
    next_s.tlbFlush = (nMode != s.mode); // [R22]

    // address shaping for the mode currently in force
    next_s.linOut = shapedAddr; // [R11] [R12] [R13]
    next_s.nonCanonical = shapedNonCanon; // [R13]
    next_s.passThrough = (s.mode == PMS_NONE); // [R4]
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s.primary <= `PMS_PRIMARY_RST;
      s.extended <= `PMS_EXTENDED_RST;
      s.feature <= `PMS_FEATURE_RST;
      s.mode <= PMS_NONE;
      s.mods <= '0;
      s.geom <= '0;
      s.wrAck <= 1'b0;
      s.fault <= 1'b0;
      s.tlbFlush <= 1'b0;
      s.linOut <= 64'h0000_0000_0000_0000;
      s.nonCanonical <= 1'b0;
      s.passThrough <= 1'b1;
    end
    else
    begin
      s <= next_s; // [R28]
    end
  end

  assign wrAck = s.wrAck;
  assign fault = s.fault;
  assign primarySystemControl = s.primary;
  assign extendedSystemControl = s.extended;
  assign extendedFeatureEnable = s.feature;
  assign mode = s.mode;
  assign mods = s.mods;
  assign geom = s.geom;
  assign tlbFlush = s.tlbFlush;
  assign linOut = s.linOut;
  assign nonCanonical = s.nonCanonical;
  assign passThrough = s.passThrough;

endmodule

// ### dv/pms_checker_sva.sv
module pms_checker
  import pms_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register side
  input wire logic wrEn,
  input wire logic wrAck,
  input wire logic fault,
  input wire logic [31:0] primarySystemControl,
  input wire logic [31:0] extendedSystemControl,
  input wire logic [63:0] extendedFeatureEnable,
  // translation side
  input wire pms_mode_t mode,
  input wire pms_mods_t mods,
  input wire logic [63:0] linAddr,
  input wire logic linIs64,
  input wire logic [63:0] linOut,
  input wire logic nonCanonical
);
  timeunit 1ns;
  timeprecision 1ps;
  wire pg = primarySystemControl[31];
  wire physical_extension_enable = extendedSystemControl[5];
  wire long_mode_enable = extendedFeatureEnable[8];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  chk_ack_follows: assert property (wrEn |=> wrAck)
    else $error("write not acknowledged");
  chk_fault_keeps: assert property (fault |-> $stable(primarySystemControl)
    && $stable(extendedSystemControl) && $stable(extendedFeatureEnable))
    else $error("refused write changed a register");
  chk_lma_tracks: assert property (extendedFeatureEnable[10] == (pg && long_mode_enable))
    else $error("long mode active out of step");
  chk_pg_needs_pe: assert property (pg |-> primarySystemControl[0])
    else $error("paging on without protection");
  chk_off_quiet: assert property (!pg |-> mode == PMS_NONE && mods == '0)
    else $error("paging off but mode or modifiers set");
  chk_mode_decode: assert property (pg |-> mode == (!physical_extension_enable ? PMS_BITS32 :
    (long_mode_enable ? PMS_WIDE : PMS_EXTPHYS)))
    else $error("wrong paging mode");
  chk_legacy_lme: assert property (pg && !physical_extension_enable |-> !long_mode_enable)
    else $error("long mode set in 32-bit mode");
  chk_nx_mask: assert property (mods.noExecute ==
    (extendedFeatureEnable[11] && mode inside {PMS_EXTPHYS, PMS_WIDE}))
    else $error("no-execute enable mismasked");
  chk_ctx_mask: assert property (mods.contextId ==
    (extendedSystemControl[17] && mode == PMS_WIDE))
    else $error("context id enable mismasked");
  chk_legacy_lin: assert property (mode inside {PMS_BITS32, PMS_EXTPHYS} |=>
    linOut[63:32] == 32'h0000_0000)
    else $error("legacy linear address too wide");
  chk_canon_flag: assert property (mode == PMS_WIDE && linIs64 |=> nonCanonical ==
    ($past(linAddr[63:47]) != 17'h0_0000 && $past(linAddr[63:47]) != 17'h1_ffff))
    else $error("canonical check wrong");
endmodule

// ### dv/pms_exec_model.sv
module pms_exec_model
  import pms_pkg::*;
(
  // answer from the block
  input wire logic clk_sys,
  input wire logic wrAck,
  input wire logic fault,
  // write request
  output logic wrEn,
  output pms_reg_sel_t wrSel,
  output logic [63:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastFault = 1'b0;
  initial
  begin
    wrEn = 1'b0;
    wrSel = PMS_SEL_PRIMARY;
    wrData = 64'h0000_0000_0000_0000;
  end
  // one-cycle request; the answer stands for the cycle after the accepting edge
  task automatic put(input pms_reg_sel_t sel, input logic [63:0] data);
    @(posedge clk_sys);
    wrEn <= 1'b1;
    wrSel <= sel;
    wrData <= data;
    @(posedge clk_sys);
    wrEn <= 1'b0;
    wrData <= ~data;
    #1;
    lastFault = wrAck ? fault : 1'bx;
  endtask
endmodule

// ### dv/pms_paging_mode_select_bench.sv
module pms_paging_mode_select_bench
  import pms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    pms_reg_sel_t sel;
    logic [31:0] data;
    logic flt;
    pms_mode_t md;
    pms_mods_t mods;
  } pms_row_t;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wrEn, wrAck, fault, tlbFlush, nonCanonical, passThrough;
  logic linIs64 = 1'b0;
  logic [63:0] linAddr = 64'h0000_0000_0000_0000;
  logic [63:0] wrData, linOut, extendedFeatureEnable;
  logic [31:0] primarySystemControl, extendedSystemControl;
  pms_reg_sel_t wrSel;
  pms_mode_t mode;
  pms_mods_t mods;
  pms_geom_t geom;
  int fails = 0;
  int cmpCount = 0;
  int cycles = 0;
  pms_mode_t prevMd = PMS_NONE;
  pms_row_t rows [14] = '{
    '{PMS_SEL_PRIMARY, 32'h8000_0000, 1'b1, PMS_NONE, 6'h00},
    '{PMS_SEL_PRIMARY, 32'h0000_0001, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_FEATURE, 32'h0000_0100, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_PRIMARY, 32'h8000_0001, 1'b1, PMS_NONE, 6'h00},
    '{PMS_SEL_FEATURE, 32'h0000_0400, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_PRIMARY, 32'h8001_0001, 1'b0, PMS_BITS32, 6'h20},
    '{PMS_SEL_EXTENDED, 32'h0000_0020, 1'b0, PMS_EXTPHYS, 6'h20},
    '{PMS_SEL_FEATURE, 32'h0000_0100, 1'b1, PMS_EXTPHYS, 6'h20},
    '{PMS_SEL_PRIMARY, 32'h0000_0001, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_FEATURE, 32'h0000_0900, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_EXTENDED, 32'h0002_00a0, 1'b0, PMS_NONE, 6'h00},
    '{PMS_SEL_PRIMARY, 32'h8001_0001, 1'b0, PMS_WIDE, 6'h2d},
    '{PMS_SEL_EXTENDED, 32'h0002_0080, 1'b1, PMS_WIDE, 6'h2d},
    '{PMS_SEL_PRIMARY, 32'h0000_0001, 1'b1, PMS_WIDE, 6'h2d}
  };
  always #2 clk_sys = ~clk_sys;
  pms_paging_mode_select DUT (.clk_sys, .resetn, .wrEn, .wrSel, .wrData, .wrAck, .fault,
    .primarySystemControl, .extendedSystemControl, .extendedFeatureEnable, .mode, .mods,
    .geom, .tlbFlush, .linAddr, .linIs64, .linOut, .nonCanonical, .passThrough);
  pms_exec_model EXU (.clk_sys, .wrAck, .fault, .wrEn, .wrSel, .wrData);
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic lin(input logic [63:0] a, input logic is64, input logic [63:0] e, input logic nc);
    @(posedge clk_sys);
    linAddr <= a;
    linIs64 <= is64;
    @(posedge clk_sys);
    #1;
    check("linOut", linOut, e);
    check("nonCanonical", nonCanonical, nc);
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("passThrough", passThrough, 1'b1);
    check("feature", extendedFeatureEnable, 64'h0000_0000_0000_0000);
    lin(64'hffff_ffff_89ab_cdef, 1'b1, 64'h0000_0000_89ab_cdef, 1'b0);
    for (int i = 0; i < 14; i++)
    begin
      EXU.put(rows[i].sel, {32'h0000_0000, rows[i].data});
      check("fault", EXU.lastFault, rows[i].flt);
      check("mode", mode, rows[i].md);
      check("mods", mods, rows[i].mods);
      check("tlbFlush", tlbFlush, {63'h0, rows[i].md != prevMd});
      prevMd = rows[i].md;
    end
    check("feature", extendedFeatureEnable, 64'h0000_0000_0000_0d00);
    check("linWidth", geom.linWidth, 7'h30);
    check("page1g", geom.page1g, 1'b1);
    lin(64'hffff_8000_1234_5678, 1'b1, 64'h0000_8000_1234_5678, 1'b0);
    lin(64'h0000_8000_0000_0000, 1'b1, 64'h0000_8000_0000_0000, 1'b1);
    lin(64'hffff_ffff_89ab_cdef, 1'b0, 64'h0000_0000_89ab_cdef, 1'b0);
    check("passThrough", passThrough, 1'b0);
    check("physWidthSmall", geom.physWidthSmall, 6'h34);
    check("physWidthLarge", geom.physWidthLarge, 6'h34);
    resetn <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("mode", mode, PMS_NONE);
    check("primary", primarySystemControl, 32'h0000_0000);
    conclude();
  end
endmodule
bind pms_paging_mode_select pms_checker u_chk (.clk_sys, .resetn, .wrEn, .wrAck, .fault,
  .primarySystemControl, .extendedSystemControl, .extendedFeatureEnable, .mode, .mods,
  .linAddr, .linIs64, .linOut, .nonCanonical);
